// file: logic/ccr_pkg.sv
// package: register map, field layout and constants of the coefficient config block
package ccr_pkg;
  // =========================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] CCR_IDX_PULSE_FORMAT = 10'h00F;
  localparam logic [9:0] CCR_IDX_PULSE_LENGTH = 10'h010;
  localparam logic [9:0] CCR_IDX_SHADOW_ADDRESS = 10'h011;
  localparam logic [9:0] CCR_IDX_SHADOW_DATA = 10'h012;
  localparam logic [9:0] CCR_IDX_UPDATE_MASK = 10'h013;
  localparam logic [9:0] CCR_IDX_DELAY_MASK = 10'h014;
  // =========================================================
  // reset values
  localparam logic [15:0] CCR_RST_PULSE_FORMAT = 16'h0000;
  localparam logic [15:0] CCR_RST_PULSE_LENGTH = 16'h0000;
  localparam logic [15:0] CCR_RST_SHADOW_ADDRESS = 16'h0000;
  localparam logic [15:0] CCR_RST_UPDATE_MASK = 16'h00FF;
  localparam logic [15:0] CCR_RST_DELAY_MASK = 16'h00FF;
  // =========================================================
  // field layout
  localparam int CCR_FMT_COMPLEX_BIT = 0;
  localparam int CCR_FMT_MIRROR_BIT = 1;
  localparam int CCR_FMT_HYST_LSB = 8;
  localparam int CCR_HYST_W = 4;
  localparam int CCR_LEN_W = 8;
  localparam int CCR_ADDR_W = 10;
  localparam int CCR_DATA_W = 16;
  localparam int CCR_UPD_W = 8;
  localparam int CCR_STAGE_W = 4;
  // writable bits of each register; the rest read as zero, except delay mask bits 7:4, which read as one until the first write
  localparam logic [15:0] CCR_MASK_PULSE_FORMAT = 16'h0F03;
  localparam logic [15:0] CCR_MASK_PULSE_LENGTH = 16'h00FF;
  localparam logic [15:0] CCR_MASK_SHADOW_ADDRESS = 16'h03FF;
  localparam logic [15:0] CCR_MASK_UPDATE_MASK = 16'h00FF;
  localparam logic [15:0] CCR_MASK_DELAY_MASK = 16'h000F;
  // =========================================================
  // shadow ram
  localparam int CCR_SHADOW_DEPTH = 768;
  localparam logic [9:0] CCR_SHADOW_LAST = 10'h2FF;
  localparam logic [9:0] CCR_ADDR_ONE = 10'h001;
  // =========================================================
  // load sequencer states
  typedef enum logic [0:0] {
    CCR_SEQ_IDLE = 1'b0,
    CCR_SEQ_RUN = 1'b1
  } ccr_seq_t;
endpackage

// file: logic/ccr_cancel_coef_config_regs.sv
// cancellation coefficient configuration registers, shadow ram and canceler load sequencer
//
// How it works
// - format bit 0 picks real coefficients at 0, complex at 1.
// - mirrored mode walks index 0 up to N-1 then back to 0.
// - format bits 11:8 hold peak hysteresis count; software keeps it 0 to 6.
// - length bits 7:0 give unique coefficient count, mirror bit ignored when complex.
// - address register holds 10-bit word address 0..1023, shadow ram at 0..767; upper bits reserved.
// - each data register access uses current address then increments it.
// - data register moves one 16-bit word to or from shadow ram.
// - update mask bit 1 loads matching canceler ram on coef sync; resets 0x00FF.
// - delay mask bits 3:0 pick stages loading delay on delay sync; resets 0x00FF.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module ccr_cancel_coef_config_regs
  import ccr_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sync event pins from outside the clock domain
  input wire logic coef_sync_in,
  input wire logic delay_sync_in,
  // static configuration to the cancel datapath
  output logic coef_complex,
  output logic coef_mirrored,
  output logic [CCR_HYST_W-1:0] peak_hysteresis_count,
  output logic [CCR_LEN_W-1:0] unique_coef_count,
  // canceler ram write stream
  output logic coef_wr_valid,
  output logic [CCR_ADDR_W-1:0] coef_wr_index,
  output logic [CCR_DATA_W-1:0] coef_wr_data,
  output logic [CCR_UPD_W-1:0] coef_wr_select,
  output logic coef_load_busy,
  // per-stage delay load pulse
  output logic [CCR_STAGE_W-1:0] stage_delay_load
);

  // ==========================================================
  // register state
  logic [15:0] pulse_format, next_pulse_format;
  logic [15:0] pulse_length, next_pulse_length;
  logic [15:0] shadow_ram_address, next_shadow_ram_address;
  logic [15:0] canceler_update_mask, next_canceler_update_mask;
  logic [15:0] stage_delay_mask, next_stage_delay_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [CCR_DATA_W-1:0] shadow_ram [CCR_SHADOW_DEPTH];
  logic [9:0] reg_idx;
  logic access, done, mapped, in_range;
  logic [CCR_ADDR_W-1:0] cur_addr;
  logic [15:0] rd_value;

  assign reg_idx = paddr[11:2];
  assign access = psel & penable;
  // a request completes only on the edge where pready is seen high
  assign done = access & pready;
  assign cur_addr = shadow_ram_address[CCR_ADDR_W-1:0];
  assign in_range = cur_addr <= CCR_SHADOW_LAST;
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0) &&
                  (reg_idx >= CCR_IDX_PULSE_FORMAT) && (reg_idx <= CCR_IDX_DELAY_MASK);

  // ==========================================================
  // read mux
  always_comb begin
    rd_value = 16'h0000;
    case (reg_idx)
      CCR_IDX_PULSE_FORMAT: rd_value = pulse_format;
      CCR_IDX_PULSE_LENGTH: rd_value = pulse_length;
      CCR_IDX_SHADOW_ADDRESS: rd_value = shadow_ram_address;
      // out-of-range locations read as zero rather than alias
      CCR_IDX_SHADOW_DATA: rd_value = in_range ? shadow_ram[cur_addr] : 16'h0000;
      CCR_IDX_UPDATE_MASK: rd_value = canceler_update_mask;
      CCR_IDX_DELAY_MASK: rd_value = stage_delay_mask;
      default: rd_value = 16'h0000;
    endcase
  end

  // ==========================================================
  // register next values
  always_comb begin
    next_pulse_format = pulse_format;
    next_pulse_length = pulse_length;
    next_shadow_ram_address = shadow_ram_address;
    next_canceler_update_mask = canceler_update_mask;
    next_stage_delay_mask = stage_delay_mask;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // one wait state: answer is latched in the first access cycle
    if (access && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      next_prdata = (mapped && !pwrite) ? {16'h0000, rd_value} : 32'h0000_0000;
    end
    if (done && mapped && pwrite) begin
      case (reg_idx)
        CCR_IDX_PULSE_FORMAT: next_pulse_format = pwdata[15:0] & CCR_MASK_PULSE_FORMAT;
        CCR_IDX_PULSE_LENGTH: next_pulse_length = pwdata[15:0] & CCR_MASK_PULSE_LENGTH;
        CCR_IDX_SHADOW_ADDRESS: next_shadow_ram_address = pwdata[15:0] & CCR_MASK_SHADOW_ADDRESS;
        CCR_IDX_UPDATE_MASK: next_canceler_update_mask = pwdata[15:0] & CCR_MASK_UPDATE_MASK;
        CCR_IDX_DELAY_MASK: next_stage_delay_mask = pwdata[15:0] & CCR_MASK_DELAY_MASK;
        default: next_pulse_format = pulse_format;
      endcase
    end
    // data port access advances the address, wrapping after the last word
    if (done && mapped && reg_idx == CCR_IDX_SHADOW_DATA) begin
      next_shadow_ram_address = (cur_addr >= CCR_SHADOW_LAST) ? 16'h0000 :
                                {6'h00, cur_addr + CCR_ADDR_ONE};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_format <= CCR_RST_PULSE_FORMAT;
      pulse_length <= CCR_RST_PULSE_LENGTH;
      shadow_ram_address <= CCR_RST_SHADOW_ADDRESS;
      canceler_update_mask <= CCR_RST_UPDATE_MASK;
      stage_delay_mask <= CCR_RST_DELAY_MASK;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pulse_format <= next_pulse_format;
      pulse_length <= next_pulse_length;
      shadow_ram_address <= next_shadow_ram_address;
      canceler_update_mask <= next_canceler_update_mask;
      stage_delay_mask <= next_stage_delay_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // shadow ram write port, no reset on the storage
  always_ff @(posedge pclk) begin
    if (done && mapped && pwrite && reg_idx == CCR_IDX_SHADOW_DATA && in_range) begin
      shadow_ram[cur_addr] <= pwdata[CCR_DATA_W-1:0];
    end
  end

  // ==========================================================
  // static configuration outputs
  assign coef_complex = pulse_format[CCR_FMT_COMPLEX_BIT];
  assign coef_mirrored = pulse_format[CCR_FMT_MIRROR_BIT];
  // software keeps this within 0 to 6; the field is passed as written
  assign peak_hysteresis_count = pulse_format[CCR_FMT_HYST_LSB +: CCR_HYST_W];
  assign unique_coef_count = pulse_length[CCR_LEN_W-1:0];

  // ==========================================================
  // sync pin synchronisers and edge detect
  logic [1:0] coef_sync_meta, delay_sync_meta;
  logic coef_sync_last, delay_sync_last;
  logic coef_sync_evt, delay_sync_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coef_sync_meta <= 2'h0;
      delay_sync_meta <= 2'h0;
      coef_sync_last <= 1'b0;
      delay_sync_last <= 1'b0;
    end else begin
      coef_sync_meta <= {coef_sync_meta[0], coef_sync_in};
      delay_sync_meta <= {delay_sync_meta[0], delay_sync_in};
      coef_sync_last <= coef_sync_meta[1];
      delay_sync_last <= delay_sync_meta[1];
    end
  end

  assign coef_sync_evt = coef_sync_meta[1] & ~coef_sync_last;
  assign delay_sync_evt = delay_sync_meta[1] & ~delay_sync_last;

  // ==========================================================
  // stage delay load pulse
  logic [CCR_STAGE_W-1:0] next_stage_delay_load;

  always_comb begin
    next_stage_delay_load = delay_sync_evt ? stage_delay_mask[CCR_STAGE_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_delay_load <= '0;
    end else begin
      stage_delay_load <= next_stage_delay_load;
    end
  end

  // ==========================================================
  // canceler load sequencer
  // settings are captured at the sync so a mid-load write cannot tear the pulse
  ccr_seq_t seq_state, next_seq_state;
  logic [CCR_ADDR_W-1:0] seq_pos, next_seq_pos;
  logic [CCR_ADDR_W-1:0] seq_total, next_seq_total;
  logic [CCR_ADDR_W-1:0] seq_n, next_seq_n;
  logic seq_mirror, next_seq_mirror;
  logic [CCR_UPD_W-1:0] seq_select, next_seq_select;
  logic [CCR_ADDR_W-1:0] src_idx;
  logic [CCR_ADDR_W-1:0] len_ext;
  logic next_wr_valid;
  logic [CCR_ADDR_W-1:0] next_wr_index;
  logic [CCR_DATA_W-1:0] next_wr_data;
  logic [CCR_UPD_W-1:0] next_wr_select;

  assign len_ext = {2'h0, unique_coef_count};

  always_comb begin
    // mirrored walk folds back over the stored half
    src_idx = seq_pos;
    if (seq_mirror && seq_pos >= seq_n) begin
      src_idx = (seq_n << 1) - 10'h002 - seq_pos;
    end
  end

  always_comb begin
    next_seq_state = seq_state;
    next_seq_pos = seq_pos;
    next_seq_total = seq_total;
    next_seq_n = seq_n;
    next_seq_mirror = seq_mirror;
    next_seq_select = seq_select;
    next_wr_valid = 1'b0;
    next_wr_index = coef_wr_index;
    next_wr_data = coef_wr_data;
    next_wr_select = coef_wr_select;
    case (seq_state)
      CCR_SEQ_IDLE: begin
        if (coef_sync_evt && canceler_update_mask[CCR_UPD_W-1:0] != '0 && len_ext != '0) begin
          next_seq_state = CCR_SEQ_RUN;
          next_seq_pos = '0;
          next_seq_n = len_ext;
          next_seq_select = canceler_update_mask[CCR_UPD_W-1:0];
          // complex pulses hold an i and a q word per coefficient
          if (coef_complex) begin
            next_seq_mirror = 1'b0;
            next_seq_total = len_ext << 1;
          end else if (coef_mirrored) begin
            next_seq_mirror = 1'b1;
            next_seq_total = (len_ext << 1) - CCR_ADDR_ONE;
          end else begin
            next_seq_mirror = 1'b0;
            next_seq_total = len_ext;
          end
        end
      end
      CCR_SEQ_RUN: begin
        next_wr_valid = 1'b1;
        next_wr_index = seq_pos;
        next_wr_data = shadow_ram[src_idx];
        next_wr_select = seq_select;
        next_seq_pos = seq_pos + CCR_ADDR_ONE;
        if (seq_pos == seq_total - CCR_ADDR_ONE) begin
          next_seq_state = CCR_SEQ_IDLE;
        end
      end
      default: next_seq_state = CCR_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= CCR_SEQ_IDLE;
      seq_pos <= '0;
      seq_total <= '0;
      seq_n <= '0;
      seq_mirror <= 1'b0;
      seq_select <= '0;
      coef_wr_valid <= 1'b0;
      coef_wr_index <= '0;
      coef_wr_data <= '0;
      coef_wr_select <= '0;
    end else begin
      seq_state <= next_seq_state;
      seq_pos <= next_seq_pos;
      seq_total <= next_seq_total;
      seq_n <= next_seq_n;
      seq_mirror <= next_seq_mirror;
      seq_select <= next_seq_select;
      coef_wr_valid <= next_wr_valid;
      coef_wr_index <= next_wr_index;
      coef_wr_data <= next_wr_data;
      coef_wr_select <= next_wr_select;
    end
  end

  assign coef_load_busy = (seq_state == CCR_SEQ_RUN) | coef_wr_valid;

endmodule

// file: tb/ccr_cancel_coef_config_regs_properties.sv
// checker: port-level properties of the coefficient config block
`timescale 1ns/1ps
module ccr_cancel_coef_config_regs_properties
  import ccr_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // datapath side
  input wire logic coef_complex,
  input wire logic coef_mirrored,
  input wire logic [CCR_HYST_W-1:0] peak_hysteresis_count,
  input wire logic [CCR_LEN_W-1:0] unique_coef_count,
  input wire logic coef_wr_valid,
  input wire logic [CCR_UPD_W-1:0] coef_wr_select,
  input wire logic coef_load_busy,
  input wire logic [CCR_STAGE_W-1:0] stage_delay_load
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =========================================================
  // helpers
  wire wr_done = psel && penable && pready && pwrite && (paddr[1:0] == 2'h0);
  wire fmt_wr = wr_done && (paddr[PADDR_W-1:2] == CCR_IDX_PULSE_FORMAT);
  wire len_wr = wr_done && (paddr[PADDR_W-1:2] == CCR_IDX_PULSE_LENGTH);
  // =========================================================
  // properties
  a_complex_bit: assert property (fmt_wr |=> coef_complex == $past(pwdata[0])) else $error("complex bit");
  a_mirror_bit: assert property (fmt_wr |=> coef_mirrored == $past(pwdata[1])) else $error("mirror bit");
  a_hyst_field: assert property (fmt_wr |=> peak_hysteresis_count == $past(pwdata[11:8])) else $error("hyst");
  a_length_field: assert property (len_wr |=> unique_coef_count == $past(pwdata[7:0])) else $error("length");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_error_qualified: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_read_upper: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("prdata upper bits");
  a_select_nonzero: assert property (coef_wr_valid |-> coef_wr_select != 8'h00 && coef_load_busy) else $error("select");
  a_delay_pulse: assert property (stage_delay_load != 4'h0 |=> stage_delay_load == 4'h0) else $error("delay pulse");
  c_write: cover property (fmt_wr);
  c_coef_word: cover property (coef_wr_valid);
  c_delay_load: cover property (stage_delay_load != 4'h0);
endmodule
bind ccr_cancel_coef_config_regs ccr_cancel_coef_config_regs_properties #(.PADDR_W(PADDR_W)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .coef_complex(coef_complex),
  .coef_mirrored(coef_mirrored), .peak_hysteresis_count(peak_hysteresis_count),
  .unique_coef_count(unique_coef_count), .coef_wr_valid(coef_wr_valid), .coef_wr_select(coef_wr_select),
  .coef_load_busy(coef_load_busy), .stage_delay_load(stage_delay_load));

// file: tb/ccr_cancel_coef_config_regs_test.sv
// testbench: apb register access, shadow ram, load sequences and delay sync
`timescale 1ns/1ps
module ccr_cancel_coef_config_regs_test;
  import ccr_pkg::*;
  // =========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, coef_sync_in, delay_sync_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, coef_complex, coef_mirrored, coef_wr_valid, coef_load_busy, e;
  logic [3:0] peak_hysteresis_count, stage_delay_load, seen;
  logic [7:0] unique_coef_count, coef_wr_select;
  logic [9:0] coef_wr_index;
  logic [15:0] coef_wr_data;
  int n_errors = 0;
  int comparisons = 0;
  int n;
  ccr_cancel_coef_config_regs #(.PADDR_W(12)) i_ccr_cancel_coef_config_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .coef_sync_in(coef_sync_in),
    .delay_sync_in(delay_sync_in), .coef_complex(coef_complex), .coef_mirrored(coef_mirrored),
    .peak_hysteresis_count(peak_hysteresis_count), .unique_coef_count(unique_coef_count),
    .coef_wr_valid(coef_wr_valid), .coef_wr_index(coef_wr_index), .coef_wr_data(coef_wr_data),
    .coef_wr_select(coef_wr_select), .coef_load_busy(coef_load_busy), .stage_delay_load(stage_delay_load));
  // =========================================================
  // tasks
  task print_verdict;
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // request held until pready is sampled; answer taken at that same edge
  task apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task rd(input logic [9:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk("read data", {16'h0000, exp}, d);
    chk("slave error", 32'h0, {31'h0, e});
  endtask
  function logic [15:0] exp_word(input logic [1:0] fmt, input int j);
    exp_word = 16'hA000 + 16'((fmt == 2'h2 && j >= 15) ? 28 - j : j);
  endfunction
  // one coefficient sync; words are watched for a fixed span
  task load(input logic [1:0] fmt, input logic [7:0] mask, input int total);
    apb(1'b1, CCR_IDX_PULSE_FORMAT, {14'h0, fmt});
    apb(1'b1, CCR_IDX_UPDATE_MASK, {8'h00, mask});
    @(posedge pclk);
    coef_sync_in <= 1'b1;
    n = 0;
    for (int c = 0; c < 40; c++) begin
      @(posedge pclk);
      if (c == 6) coef_sync_in <= 1'b0;
      @(negedge pclk);
      if (coef_wr_valid === 1'b1) begin
        chk("coef_wr_index", n, {22'h0, coef_wr_index});
        chk("coef_wr_data", {16'h0, exp_word(fmt, n)}, {16'h0, coef_wr_data});
        chk("coef_wr_select", {24'h0, mask}, {24'h0, coef_wr_select});
        chk("coef_load_busy", 32'h1, {31'h0, coef_load_busy});
        n++;
      end
    end
    chk("word count", total, n);
    chk("coef_load_busy", 32'h0, {31'h0, coef_load_busy});
  endtask
  // =========================================================
  // watchdog
  initial begin
    #5000000;
    n_errors++;
    print_verdict();
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // =========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, coef_sync_in, delay_sync_in} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CCR_IDX_PULSE_FORMAT, CCR_RST_PULSE_FORMAT);
    rd(CCR_IDX_PULSE_LENGTH, CCR_RST_PULSE_LENGTH);
    rd(CCR_IDX_SHADOW_ADDRESS, CCR_RST_SHADOW_ADDRESS);
    rd(CCR_IDX_UPDATE_MASK, 16'h00FF);
    rd(CCR_IDX_DELAY_MASK, 16'h00FF);
    // reserved bits must not stick
    apb(1'b1, CCR_IDX_PULSE_FORMAT, 16'hF6FF);
    chk("fields", 32'h0000_0603, {20'h0, peak_hysteresis_count, 6'h0, coef_mirrored, coef_complex});
    rd(CCR_IDX_PULSE_FORMAT, 16'h0603);
    apb(1'b1, CCR_IDX_PULSE_LENGTH, 16'hFF0F);
    chk("unique_coef_count", 32'h0F, {24'h0, unique_coef_count});
    rd(CCR_IDX_PULSE_LENGTH, 16'h000F);
    apb(1'b1, CCR_IDX_SHADOW_ADDRESS, 16'hFFFF);
    rd(CCR_IDX_SHADOW_ADDRESS, 16'h03FF);
    // unmapped places answer with an error and zero
    apb(1'b0, 10'h00E, 16'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 10'h015, 16'h0);
    chk("unmapped data", 32'h0, d);
    // auto increment across the top of the shadow ram
    apb(1'b1, CCR_IDX_SHADOW_ADDRESS, 16'h02FE);
    for (int k = 0; k < 3; k++) apb(1'b1, CCR_IDX_SHADOW_DATA, 16'h5A00 + 16'(k));
    rd(CCR_IDX_SHADOW_ADDRESS, 16'h0001);
    apb(1'b1, CCR_IDX_SHADOW_ADDRESS, 16'h02FE);
    for (int k = 0; k < 3; k++) rd(CCR_IDX_SHADOW_DATA, 16'h5A00 + 16'(k));
    // coefficient loads in every format
    apb(1'b1, CCR_IDX_SHADOW_ADDRESS, 16'h0000);
    for (int k = 0; k < 30; k++) apb(1'b1, CCR_IDX_SHADOW_DATA, 16'hA000 + 16'(k));
    load(2'h0, 8'h01, 15);
    load(2'h2, 8'h80, 29);
    load(2'h1, 8'h20, 30);
    load(2'h0, 8'h00, 0);
    // delay sync follows the stage mask
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, CCR_IDX_DELAY_MASK, m ? 16'h000A : 16'hFFF5);
      rd(CCR_IDX_DELAY_MASK, m ? 16'h000A : 16'h0005);
      @(posedge pclk);
      delay_sync_in <= 1'b1;
      seen = 4'h0;
      n = 0;
      for (int c = 0; c < 12; c++) begin
        @(posedge pclk);
        if (c == 6) delay_sync_in <= 1'b0;
        @(negedge pclk);
        if (stage_delay_load !== 4'h0) begin
          seen = stage_delay_load;
          n++;
        end
      end
      chk("stage_delay_load", m ? 32'hA : 32'h5, {28'h0, seen});
      chk("delay pulse count", 32'h1, n);
    end
    print_verdict();
  end
endmodule
